//--- logic/ecs_status_bank.sv
// exposure control status bank: controller and sequencer report sets
// ==========================================================
// What this block does
// - exposure controller evaluates and requests new parameters only every second frame
// - with latency compensation set, gain updates land with the matching integration
// - controller-side status refreshes when a request goes to the sequencer
// - sequencer-side status refreshes only when values take effect on readout
// - sample count status reports pixels used in the statistics, 16 bits
// - mean level status reports the frame's 10-bit mean illumination
// - calculated integration and gains reported at frame end in fixed fields
// - step multiplier and array clear length reported per frame, 16 bits each
// - applied, second and third slope integration reported, 16 bits each
// - applied first stage gain 5 bits, second stage 8 bits, one word
// - applied fine gain 12 bits plus second and third slope flags
`timescale 1ns/1ns
module ecs_status_bank
	import ecs_pkg::*;
(
	input  wire logic                      clk_i,
	input  wire logic                      rstn_i,
	input  wire logic                      frame_start_i,
	input  wire logic                      frame_end_i,
	input  wire logic                      gain_lat_comp_i,
	input  wire ecs_pkg::ecs_word_t        sample_count_i,
	input  wire logic [ecs_pkg::ECS_MEAN_W-1:0] mean_level_i,
	input  wire ecs_pkg::ecs_word_t        calc_integration_i,
	input  wire logic [1:0]                calc_mux_gain_i,
	input  wire logic [1:0]                calc_afe_gain_i,
	input  wire logic [11:0]               calc_digital_gain_i,
	input  wire ecs_pkg::ecs_word_t        step_multiplier_i,
	input  wire ecs_pkg::ecs_word_t        array_clear_len_i,
	input  wire ecs_pkg::ecs_word_t        second_slope_integration_i,
	input  wire ecs_pkg::ecs_word_t        third_slope_integration_i,
	input  wire logic                      second_slope_en_i,
	input  wire logic                      third_slope_en_i,
	input  wire logic                      spi_sck_i,
	input  wire logic                      spi_ss_n_i,
	input  wire logic                      spi_mosi_i,
	output logic                           spi_miso_o,
	output logic                           spi_miso_oe_o,
	output logic                           aec_req_o,
	output ecs_pkg::ecs_word_t             applied_integration_o,
	output logic [1:0]                     applied_mux_gain_o,
	output logic [1:0]                     applied_afe_gain_o,
	output logic [11:0]                    applied_fine_gain_o
);
	import ecs_pkg::*;

	logic                  eval_phase_q;
	logic                  req;
	ecs_word_t             sample_q;
	logic [ECS_MEAN_W-1:0] mean_q;
	ecs_word_t             calc_integ_q;
	ecs_word_t             calc_gains_q;
	ecs_word_t             gain_req;
	logic                  integ_lead_v;
	ecs_word_t             integ_lead;
	logic                  integ_lag_v;
	ecs_word_t             integ_lag;
	logic                  gain_lead_v;
	ecs_word_t             gain_lead;
	logic                  gain_lag_v;
	ecs_word_t             gain_lag;
	ecs_word_t             appl_integ_q;
	ecs_word_t             appl_gain_q;
	ecs_word_t             mult_q;
	ecs_word_t             clear_q;
	ecs_word_t             slope2_q;
	ecs_word_t             slope3_q;
	logic                  slope2_en_q;
	logic                  slope3_en_q;
	ecs_word_t             seq_gain_word;
	ecs_word_t             seq_fine_word;
	ecs_word_t             rd_word;

	ecs_rd_if rd ();

	// ==========================================================
	// serial port
	ecs_spi_port u_spi (
		.clk_i         (clk_i),
		.rstn_i        (rstn_i),
		.spi_sck_i     (spi_sck_i),
		.spi_ss_n_i    (spi_ss_n_i),
		.spi_mosi_i    (spi_mosi_i),
		.spi_miso_o    (spi_miso_o),
		.spi_miso_oe_o (spi_miso_oe_o),
		.rd            (rd.port)
	);

	// ==========================================================
	// evaluation cadence
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			eval_phase_q <= 1'b0;
		else if (frame_end_i)
			eval_phase_q <= ~eval_phase_q;
	end

	assign req = frame_end_i & eval_phase_q;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			aec_req_o <= 1'b0;
		else
			aec_req_o <= req;
	end

	// ==========================================================
	// frame statistics
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sample_q <= ECS_STAT_RST;
			mean_q   <= '0;
		end
		else if (frame_end_i)
		begin
			sample_q <= sample_count_i;
			mean_q   <= mean_level_i;
		end
	end

	// ==========================================================
	// controller-side report
	assign gain_req = {calc_digital_gain_i, calc_afe_gain_i, calc_mux_gain_i};

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			calc_integ_q <= ECS_STAT_RST;
			calc_gains_q <= ECS_STAT_RST;
		end
		else if (req)
		begin
			calc_integ_q <= calc_integration_i;
			calc_gains_q <= gain_req;
		end
	end

	// ==========================================================
	// request pipelines toward readout
	ecs_frame_pipe #(.W(ECS_DW)) u_integ_pipe (
		.clk_i    (clk_i),
		.rstn_i   (rstn_i),
		.push_i   (req),
		.data_i   (calc_integration_i),
		.adv_i    (frame_start_i),
		.lead_v_o (integ_lead_v),
		.lead_o   (integ_lead),
		.lag_v_o  (integ_lag_v),
		.lag_o    (integ_lag)
	);

	ecs_frame_pipe #(.W(ECS_DW)) u_gain_pipe (
		.clk_i    (clk_i),
		.rstn_i   (rstn_i),
		.push_i   (req),
		.data_i   (gain_req),
		.adv_i    (frame_start_i),
		.lead_v_o (gain_lead_v),
		.lead_o   (gain_lead),
		.lag_v_o  (gain_lag_v),
		.lag_o    (gain_lag)
	);

	// ==========================================================
	// applied values, changed only as a frame starts
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			appl_integ_q <= ECS_STAT_RST;
		else if (frame_start_i && integ_lag_v)
			appl_integ_q <= integ_lag;
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			appl_gain_q <= ECS_STAT_RST;
		else if (frame_start_i && gain_lat_comp_i && gain_lag_v)
			appl_gain_q <= gain_lag;
		else if (frame_start_i && !gain_lat_comp_i && gain_lead_v)
			appl_gain_q <= gain_lead;
	end

	// ==========================================================
	// sequencer-side report of settings outside the controller
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			mult_q      <= ECS_STAT_RST;
			clear_q     <= ECS_STAT_RST;
			slope2_q    <= ECS_STAT_RST;
			slope3_q    <= ECS_STAT_RST;
			slope2_en_q <= 1'b0;
			slope3_en_q <= 1'b0;
		end
		else if (frame_start_i)
		begin
			mult_q      <= step_multiplier_i;
			clear_q     <= array_clear_len_i;
			slope2_q    <= second_slope_integration_i;
			slope3_q    <= third_slope_integration_i;
			slope2_en_q <= second_slope_en_i;
			slope3_en_q <= third_slope_en_i;
		end
	end

	assign applied_integration_o = appl_integ_q;
	assign applied_mux_gain_o    = appl_gain_q[ECS_CG_MUX_LSB +: ECS_CG_MUX_W];
	assign applied_afe_gain_o    = appl_gain_q[ECS_CG_AFE_LSB +: ECS_CG_AFE_W];
	assign applied_fine_gain_o   = appl_gain_q[ECS_CG_DG_LSB +: ECS_CG_DG_W];

	// ==========================================================
	// packed sequencer words
	always_comb
	begin
		seq_gain_word = ECS_STAT_RST;
		seq_gain_word[ECS_SA_MUX_LSB +: ECS_SA_MUX_W] = ECS_SA_MUX_W'(applied_mux_gain_o);
		seq_gain_word[ECS_SA_AFE_LSB +: ECS_SA_AFE_W] = ECS_SA_AFE_W'(applied_afe_gain_o);
	end

	always_comb
	begin
		seq_fine_word = ECS_STAT_RST;
		seq_fine_word[ECS_SD_DG_LSB +: ECS_CG_DG_W] = applied_fine_gain_o;
		seq_fine_word[ECS_SD_DS_BIT] = slope2_en_q;
		seq_fine_word[ECS_SD_TS_BIT] = slope3_en_q;
	end

	// ==========================================================
	// read decode; no write path exists
	always_comb
	begin
		rd_word = ECS_STAT_RST;
		case (rd.addr)
			ECS_A_SAMPLE_COUNT: rd_word = sample_q;
			ECS_A_MEAN_LEVEL:   rd_word = ECS_DW'(mean_q);
			ECS_A_CALC_INTEG:   rd_word = calc_integ_q;
			ECS_A_CALC_GAINS:   rd_word = calc_gains_q;
			ECS_A_STEP_MULT:    rd_word = mult_q;
			ECS_A_CLEAR_LEN:    rd_word = clear_q;
			ECS_A_APPL_INTEG:   rd_word = appl_integ_q;
			ECS_A_SLOPE2_TIME:  rd_word = slope2_q;
			ECS_A_SLOPE3_TIME:  rd_word = slope3_q;
			ECS_A_ANALOG_GAINS: rd_word = seq_gain_word;
			ECS_A_FINE_SLOPES:  rd_word = seq_fine_word;
			default:            rd_word = ECS_STAT_RST;
		endcase
	end

	assign rd.rd_data = rd_word;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i);
	endclocking

	default disable iff (!rstn_i);

	a_skip_frame: assert property (
		frame_end_i && !eval_phase_q |=> !aec_req_o)
		else $error("request issued on a skipped frame");

	a_eval_frame: assert property (
		frame_end_i && eval_phase_q |=> aec_req_o ##1 !aec_req_o)
		else $error("no single request on an evaluation frame");

	a_ctrl_refresh: assert property (
		aec_req_o |-> calc_integ_q == $past(calc_integration_i))
		else $error("controller integration not refreshed with request");

	a_ctrl_hold: assert property (
		!aec_req_o |-> $stable(calc_integ_q) && $stable(calc_gains_q))
		else $error("controller report changed without request");

	a_calc_fields: assert property (
		aec_req_o |-> calc_gains_q[ECS_CG_DG_LSB +: ECS_CG_DG_W] == $past(calc_digital_gain_i)
			&& calc_gains_q[ECS_CG_AFE_LSB +: ECS_CG_AFE_W] == $past(calc_afe_gain_i)
			&& calc_gains_q[ECS_CG_MUX_LSB +: ECS_CG_MUX_W] == $past(calc_mux_gain_i))
		else $error("calculated gain fields misplaced");

	a_seq_lags: assert property (
		$changed(appl_integ_q) |-> $past(frame_start_i) && $past(integ_lag_v))
		else $error("applied integration changed off a taking frame");

	a_gain_aligned: assert property (
		$changed(appl_gain_q) && $past(gain_lat_comp_i) |-> $past(gain_lag_v))
		else $error("compensated gain applied ahead of integration");

	a_gain_direct: assert property (
		frame_start_i && !gain_lat_comp_i && gain_lead_v |=> appl_gain_q == $past(gain_lead))
		else $error("uncompensated gain not applied at next frame");

	a_sample_cnt: assert property (
		frame_end_i |=> sample_q == $past(sample_count_i))
		else $error("sample count not captured at frame end");

	a_mean_level: assert property (
		frame_end_i |=> mean_q == $past(mean_level_i))
		else $error("mean level not captured at frame end");

	a_seq_timing: assert property (
		frame_start_i |=> mult_q == $past(step_multiplier_i) && clear_q == $past(array_clear_len_i))
		else $error("step multiplier or clear length not captured");

	a_slope_times: assert property (
		frame_start_i |=> slope2_q == $past(second_slope_integration_i)
			&& slope3_q == $past(third_slope_integration_i))
		else $error("slope integration not captured");

	a_ro_hold: assert property (
		!frame_start_i && !frame_end_i |=> $stable({sample_q, mean_q, mult_q, slope2_q}))
		else $error("status changed without a frame event");

	a_req_cause: assert property (
		aec_req_o |-> $past(frame_end_i) && $past(eval_phase_q))
		else $error("request without an evaluation frame end");

	a_integ_hold: assert property (
		!frame_start_i |=> $stable(appl_integ_q))
		else $error("applied integration changed between frames");

	a_gain_hold: assert property (
		!frame_start_i |=> $stable(appl_gain_q))
		else $error("applied gain changed between frames");

	a_slope_flags: assert property (
		frame_start_i |=> slope2_en_q == $past(second_slope_en_i)
			&& slope3_en_q == $past(third_slope_en_i))
		else $error("slope flags not captured at frame start");

	a_mean_pad: assert property (
		rd.addr == ECS_A_MEAN_LEVEL |-> rd_word[ECS_DW-1:ECS_MEAN_W] == '0)
		else $error("mean level upper bits not zero");

	c_req_comp:   cover property (aec_req_o && gain_lat_comp_i);
	c_integ_take: cover property (frame_start_i && integ_lag_v);
	c_gain_lead:  cover property (frame_start_i && !gain_lat_comp_i && gain_lead_v);
	c_spi_read:   cover property (spi_miso_oe_o && rd.addr == ECS_A_ANALOG_GAINS);

endmodule

//--- logic/ecs_pkg.sv
// shared constants and types for the exposure control status bank
package ecs_pkg;

	// ==========================================================
	// widths and types
	localparam int unsigned ECS_AW = 9;
	localparam int unsigned ECS_DW = 16;
	localparam int unsigned ECS_MEAN_W = 10;

	typedef logic [ECS_AW-1:0] ecs_addr_t;
	typedef logic [ECS_DW-1:0] ecs_word_t;

	typedef enum logic [1:0]
	{
		ECS_SPI_IDLE = 2'b00,
		ECS_SPI_HDR  = 2'b01,
		ECS_SPI_DATA = 2'b10
	} ecs_spi_state_t;

	// ==========================================================
	// register addresses
	localparam ecs_addr_t ECS_A_SAMPLE_COUNT = 9'h0B8;
	localparam ecs_addr_t ECS_A_MEAN_LEVEL   = 9'h0BA;
	localparam ecs_addr_t ECS_A_CALC_INTEG   = 9'h0BB;
	localparam ecs_addr_t ECS_A_CALC_GAINS   = 9'h0BC;
	localparam ecs_addr_t ECS_A_STEP_MULT    = 9'h0D0;
	localparam ecs_addr_t ECS_A_CLEAR_LEN    = 9'h0D1;
	localparam ecs_addr_t ECS_A_APPL_INTEG   = 9'h0D2;
	localparam ecs_addr_t ECS_A_SLOPE2_TIME  = 9'h0D3;
	localparam ecs_addr_t ECS_A_SLOPE3_TIME  = 9'h0D4;
	localparam ecs_addr_t ECS_A_ANALOG_GAINS = 9'h0D5;
	localparam ecs_addr_t ECS_A_FINE_SLOPES  = 9'h0D6;

	// ==========================================================
	// field layouts
	localparam int unsigned ECS_CG_MUX_LSB = 0;
	localparam int unsigned ECS_CG_MUX_W   = 2;
	localparam int unsigned ECS_CG_AFE_LSB = 2;
	localparam int unsigned ECS_CG_AFE_W   = 2;
	localparam int unsigned ECS_CG_DG_LSB  = 4;
	localparam int unsigned ECS_CG_DG_W    = 12;
	localparam int unsigned ECS_SA_MUX_LSB = 0;
	localparam int unsigned ECS_SA_MUX_W   = 5;
	localparam int unsigned ECS_SA_AFE_LSB = 5;
	localparam int unsigned ECS_SA_AFE_W   = 8;
	localparam int unsigned ECS_SD_DG_LSB  = 0;
	localparam int unsigned ECS_SD_DS_BIT  = 12;
	localparam int unsigned ECS_SD_TS_BIT  = 13;

	// ==========================================================
	// reset value and serial frame
	localparam ecs_word_t   ECS_STAT_RST   = 16'h0000;
	localparam logic [4:0]  ECS_SPI_HDR_LAST = 5'h09;
	localparam int unsigned ECS_SYNC_W     = 3;

endpackage

//--- logic/ecs_rd_if.sv
// read path between serial port and status bank
`timescale 1ns/1ns
interface ecs_rd_if;
	import ecs_pkg::*;

	ecs_addr_t addr;
	ecs_word_t rd_data;

	modport port
	(
		output addr,
		input  rd_data
	);

	modport bank
	(
		input  addr,
		output rd_data
	);
endinterface

//--- logic/ecs_frame_pipe.sv
// two-frame delay line for requested exposure parameters
`timescale 1ns/1ns
module ecs_frame_pipe #(
	parameter int unsigned W = 16
) (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic         push_i,
	input  wire logic [W-1:0] data_i,
	input  wire logic         adv_i,
	output logic              lead_v_o,
	output logic [W-1:0]      lead_o,
	output logic              lag_v_o,
	output logic [W-1:0]      lag_o
);

	// ==========================================================
	// lead stage: loaded by a request, emptied at frame start
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			lead_v_o <= 1'b0;
			lead_o   <= '0;
		end
		else if (push_i)
		begin
			lead_v_o <= 1'b1;
			lead_o   <= data_i;
		end
		else if (adv_i)
		begin
			lead_v_o <= 1'b0;
		end
	end

	// ==========================================================
	// lag stage: one frame behind the lead stage
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			lag_v_o <= 1'b0;
			lag_o   <= '0;
		end
		else if (adv_i)
		begin
			lag_v_o <= lead_v_o;
			lag_o   <= lead_o;
		end
	end

endmodule

//--- logic/ecs_spi_port.sv
// serial control port, read-only toward the status bank
`timescale 1ns/1ns
module ecs_spi_port (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic spi_sck_i,
	input  wire logic spi_ss_n_i,
	input  wire logic spi_mosi_i,
	output logic      spi_miso_o,
	output logic      spi_miso_oe_o,
	ecs_rd_if.port    rd
);
	import ecs_pkg::*;

	logic [ECS_SYNC_W-1:0] sync1_q;
	logic [ECS_SYNC_W-1:0] sync2_q;
	logic                  sck3_q;
	logic                  sck_rise;
	logic                  sck_fall;
	ecs_spi_state_t        state_q;
	logic [4:0]            cnt_q;
	logic [ECS_AW:0]       hdr_q;
	logic                  load_q;
	logic                  is_read_q;
	ecs_word_t             tx_q;

	// ==========================================================
	// pin synchronisers {sck, ss_n, mosi}
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sync1_q <= 3'h2;
			sync2_q <= 3'h2;
			sck3_q  <= 1'b0;
		end
		else
		begin
			sync1_q <= {spi_sck_i, spi_ss_n_i, spi_mosi_i};
			sync2_q <= sync1_q;
			sck3_q  <= sync2_q[2];
		end
	end

	assign sck_rise = sync2_q[2] & ~sck3_q;
	assign sck_fall = ~sync2_q[2] & sck3_q;

	// ==========================================================
	// header capture: address then direction bit
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_q   <= ECS_SPI_IDLE;
			cnt_q     <= 5'h00;
			hdr_q     <= '0;
			load_q    <= 1'b0;
			is_read_q <= 1'b0;
			rd.addr   <= '0;
		end
		else
		begin
			load_q <= 1'b0;
			case (state_q)
				ECS_SPI_IDLE:
				begin
					cnt_q <= 5'h00;
					if (!sync2_q[1])
						state_q <= ECS_SPI_HDR;
				end
				ECS_SPI_HDR:
				begin
					if (sync2_q[1])
						state_q <= ECS_SPI_IDLE;
					else if (sck_rise)
					begin
						hdr_q <= {hdr_q[ECS_AW-1:0], sync2_q[0]};
						cnt_q <= cnt_q + 5'h01;
						if (cnt_q == ECS_SPI_HDR_LAST)
						begin
							rd.addr   <= hdr_q[ECS_AW-1:0];
							is_read_q <= ~sync2_q[0];
							load_q    <= 1'b1;
							state_q   <= ECS_SPI_DATA;
						end
					end
				end
				ECS_SPI_DATA:
				begin
					if (sync2_q[1])
						state_q <= ECS_SPI_IDLE;
				end
				default:
					state_q <= ECS_SPI_IDLE;
			endcase
		end
	end

	// ==========================================================
	// read data shifter; write data on mosi is not captured
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			tx_q       <= ECS_STAT_RST;
			spi_miso_o <= 1'b0;
		end
		else if (load_q)
		begin
			tx_q <= is_read_q ? rd.rd_data : ECS_STAT_RST;
		end
		else if (state_q == ECS_SPI_DATA && sck_fall)
		begin
			spi_miso_o <= tx_q[ECS_DW-1];
			tx_q       <= {tx_q[ECS_DW-2:0], 1'b0};
		end
	end

	assign spi_miso_oe_o = (state_q == ECS_SPI_DATA) && is_read_q;

endmodule

//--- dv/ecs_status_bank_tb_top.sv
// self-checking bench for the exposure control status bank
`timescale 1ns/1ns
module ecs_status_bank_tb_top;
	import ecs_pkg::*;

	// ==========================================================
	// stimulus and observed signals
	logic             clk_i = 1'b0;
	logic             rstn_i = 1'b0;
	logic             fs = 1'b0;
	logic             fe = 1'b0;
	logic             comp = 1'b0;
	ecs_word_t        samp = '0;
	logic [ECS_MEAN_W-1:0] mean = '0;
	ecs_word_t        integ = '0;
	logic [1:0]       mux = '0;
	logic [1:0]       afe = '0;
	logic [11:0]      dg = '0;
	ecs_word_t        step = '0;
	ecs_word_t        clr = '0;
	ecs_word_t        s2 = '0;
	ecs_word_t        s3 = '0;
	logic             ds = 1'b0;
	logic             ts = 1'b0;
	logic             sck = 1'b0;
	logic             ss_n = 1'b1;
	logic             mosi = 1'b0;
	logic             miso;
	logic             miso_oe;
	logic             req;
	ecs_word_t        ap_int;
	logic [1:0]       ap_mux;
	logic [1:0]       ap_afe;
	logic [11:0]      ap_fine;
	int               error_cnt = 0;
	int               checks_done = 0;
	int               req_cnt = 0;
	logic             oe_seen = 1'b0;
	logic             oe_rd = 1'b0;
	ecs_word_t        rd;
	ecs_addr_t        regs [0:12] = '{9'h0B8, 9'h0BA, 9'h0BB, 9'h0BC, 9'h0D0, 9'h0D1, 9'h0D2,
		9'h0D3, 9'h0D4, 9'h0D5, 9'h0D6, 9'h0B9, 9'h1FF};

	always #5 clk_i = ~clk_i;

	ecs_status_bank ecs_status_bank_inst
	(
		.clk_i                      (clk_i),
		.rstn_i                     (rstn_i),
		.frame_start_i              (fs),
		.frame_end_i                (fe),
		.gain_lat_comp_i            (comp),
		.sample_count_i             (samp),
		.mean_level_i               (mean),
		.calc_integration_i         (integ),
		.calc_mux_gain_i            (mux),
		.calc_afe_gain_i            (afe),
		.calc_digital_gain_i        (dg),
		.step_multiplier_i          (step),
		.array_clear_len_i          (clr),
		.second_slope_integration_i (s2),
		.third_slope_integration_i  (s3),
		.second_slope_en_i          (ds),
		.third_slope_en_i           (ts),
		.spi_sck_i                  (sck),
		.spi_ss_n_i                 (ss_n),
		.spi_mosi_i                 (mosi),
		.spi_miso_o                 (miso),
		.spi_miso_oe_o              (miso_oe),
		.aec_req_o                  (req),
		.applied_integration_o      (ap_int),
		.applied_mux_gain_o         (ap_mux),
		.applied_afe_gain_o         (ap_afe),
		.applied_fine_gain_o        (ap_fine)
	);

	always @(negedge clk_i)
	begin
		if (req === 1'b1)
			req_cnt++;
	end

	// ==========================================================
	// helper tasks
	task automatic clks(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic check(input ecs_word_t seen, input ecs_word_t exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one serial transfer: 9 address bits, direction, 16 data bits
	task automatic xfer(input ecs_addr_t a, input logic wr, input ecs_word_t wd,
		output ecs_word_t rdat);
		logic b;
		rdat = '0;
		@(posedge clk_i) ss_n <= 1'b0;
		clks(6);
		for (int i = 0; i < 26; i++)
		begin
			b = (i < 9) ? a[8-i] : (i == 9) ? wr : wd[25-i];
			@(posedge clk_i) mosi <= b;
			clks(5);
			@(negedge clk_i);
			if (i >= 10)
				rdat[25-i] = miso;
			oe_seen = oe_seen | (wr & (miso_oe === 1'b1));
			oe_rd = oe_rd | (~wr & (miso_oe === 1'b1));
			@(posedge clk_i) sck <= 1'b1;
			clks(5);
			@(posedge clk_i) sck <= 1'b0;
		end
		clks(6);
		@(posedge clk_i) ss_n <= 1'b1;
		clks(8);
	endtask

	task automatic rd_chk(input ecs_addr_t a, input ecs_word_t exp);
		ecs_word_t v;
		xfer(a, 1'b0, 16'h0000, v);
		check(v, exp);
	endtask

	task automatic pulse_fe();
		@(posedge clk_i) fe <= 1'b1;
		@(posedge clk_i) fe <= 1'b0;
		clks(3);
	endtask

	task automatic pulse_fs();
		@(posedge clk_i) fs <= 1'b1;
		@(posedge clk_i) fs <= 1'b0;
		clks(3);
	endtask

	// ==========================================================
	// watchdog
	initial
	begin
		clks(100000);
		error_cnt++;
		end_sim();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		clks(16);
		@(posedge clk_i) rstn_i <= 1'b1;
		clks(4);
		foreach (regs[i])
			rd_chk(regs[i], ECS_STAT_RST);
		check({15'h0000, oe_rd}, 16'h0001);
		$display("test reset values done");

		@(posedge clk_i)
		begin
			samp  <= 16'h1234;
			mean  <= 10'h3FF;
			integ <= 16'hA5C3;
			mux   <= 2'h1;
			afe   <= 2'h3;
			dg    <= 12'hABC;
			step  <= 16'h0102;
			clr   <= 16'h0304;
			s2    <= 16'h0506;
			s3    <= 16'h0708;
			ds    <= 1'b1;
			ts    <= 1'b0;
		end
		pulse_fe();
		check(16'(req_cnt), 16'h0000);
		rd_chk(ECS_A_SAMPLE_COUNT, 16'h1234);
		rd_chk(ECS_A_MEAN_LEVEL, 16'h03FF);
		rd_chk(ECS_A_CALC_INTEG, 16'h0000);
		pulse_fe();
		check(16'(req_cnt), 16'h0001);
		rd_chk(ECS_A_CALC_INTEG, 16'hA5C3);
		rd_chk(ECS_A_CALC_GAINS, 16'hABCD);
		check(ap_int, 16'h0000);
		rd_chk(ECS_A_APPL_INTEG, 16'h0000);
		$display("test controller report done");

		pulse_fs();
		check({6'h00, ap_afe, 6'h00, ap_mux}, 16'h0301);
		check({4'h0, ap_fine}, 16'h0ABC);
		check(ap_int, 16'h0000);
		rd_chk(ECS_A_STEP_MULT, 16'h0102);
		rd_chk(ECS_A_CLEAR_LEN, 16'h0304);
		rd_chk(ECS_A_SLOPE2_TIME, 16'h0506);
		rd_chk(ECS_A_SLOPE3_TIME, 16'h0708);
		rd_chk(ECS_A_ANALOG_GAINS, 16'h0061);
		rd_chk(ECS_A_FINE_SLOPES, 16'h1ABC);
		pulse_fs();
		check(ap_int, 16'hA5C3);
		rd_chk(ECS_A_APPL_INTEG, 16'hA5C3);
		$display("test uncompensated apply done");

		@(posedge clk_i)
		begin
			comp  <= 1'b1;
			integ <= 16'h0F0F;
			mux   <= 2'h0;
			afe   <= 2'h2;
			dg    <= 12'h123;
			ds    <= 1'b0;
			ts    <= 1'b1;
		end
		pulse_fe();
		check(16'(req_cnt), 16'h0001);
		pulse_fe();
		check(16'(req_cnt), 16'h0002);
		rd_chk(ECS_A_CALC_INTEG, 16'h0F0F);
		pulse_fs();
		check({6'h00, ap_afe, 6'h00, ap_mux}, 16'h0301);
		check(ap_int, 16'hA5C3);
		rd_chk(ECS_A_FINE_SLOPES, 16'h2ABC);
		pulse_fs();
		check({6'h00, ap_afe, 6'h00, ap_mux}, 16'h0200);
		check({4'h0, ap_fine}, 16'h0123);
		check(ap_int, 16'h0F0F);
		rd_chk(ECS_A_ANALOG_GAINS, 16'h0040);
		rd_chk(ECS_A_FINE_SLOPES, 16'h2123);
		$display("test compensated apply done");

		xfer(ECS_A_CALC_INTEG, 1'b1, 16'hFFFF, rd);
		xfer(ECS_A_APPL_INTEG, 1'b1, 16'h5555, rd);
		check({15'h0000, oe_seen}, 16'h0000);
		rd_chk(ECS_A_CALC_INTEG, 16'h0F0F);
		rd_chk(ECS_A_APPL_INTEG, 16'h0F0F);
		check(ap_int, 16'h0F0F);
		rd_chk(9'h0B9, 16'h0000);
		$display("test write refusal done");
		end_sim();
	end
endmodule
